/* File: hw/bcr_pkg.sv */
// shared constants and lane helpers for the bus clock/reset link
package bcr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // data sizes and widths

  localparam int DATA_W = 32; // natural bus data width
  localparam int ADDR_W = 32; // address width
  localparam logic [2:0] SIZE_BYTE = 3'h0; // 8 bits
  localparam logic [2:0] SIZE_HALF = 3'h1; // 16 bits
  localparam logic [2:0] SIZE_WORD = 3'h2; // 32 bits
  localparam logic [2:0] SIZE_DWORD = 3'h3; // 64 bits, unsigned

  //////////////////////////////////////////////////////////////////////////
  // transfer type and burst encodings

  localparam logic [1:0] TRANS_IDLE = 2'h0; // no transfer
  localparam logic [1:0] TRANS_NONSEQ = 2'h2; // first beat
  localparam logic [1:0] TRANS_SEQ = 2'h3; // later beat of a burst
  localparam logic [2:0] BURST_SINGLE = 3'h0; // single transfer
  localparam logic [2:0] BURST_INCR4 = 3'h3; // four-beat incrementing
  localparam logic [1:0] INCR4_LEFT = 2'h3; // beats still to issue
  localparam logic RESP_OKAY = 1'h0; // good completion
  localparam logic RESP_ERROR = 1'h1; // two-cycle error

  //////////////////////////////////////////////////////////////////////////
  // reset values

  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000; // valid level
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000; // data reset
  localparam logic READY_RESET = 1'h1; // slave ready during reset

  //////////////////////////////////////////////////////////////////////////
  // helpers for the two ends: lane_mask serves the slave, lane_place the master, the rest both

  // aligned when the address is a multiple of the size in bytes
  function automatic logic is_aligned(input logic [1:0] off,
                                      input logic [2:0] size);
    unique case (size)
      SIZE_BYTE: is_aligned = 1'h1;
      SIZE_HALF: is_aligned = ~off[0];
      SIZE_WORD: is_aligned = (off == 2'h0);
      default: is_aligned = 1'h0; // wider than the 32-bit bus
    endcase
  endfunction : is_aligned

  // lowest byte lane used by a transfer of this size and offset
  function automatic logic [1:0] lane_index(input logic [1:0] off,
                                            input logic [2:0] size,
                                            input logic big);
    logic [1:0] last;
    last = (size == SIZE_HALF) ? 2'h1 : (size == SIZE_WORD) ? 2'h3 : 2'h0;
    // big-endian: higher addresses carry less significant bytes
    lane_index = big ? 2'h3 - off - last : off;
  endfunction : lane_index

  // active byte lanes of a transfer
  function automatic logic [3:0] lane_mask(input logic [1:0] off,
                                           input logic [2:0] size,
                                           input logic big);
    logic [3:0] base;
    base = (size == SIZE_HALF) ? 4'h3 : (size == SIZE_WORD) ? 4'hF : 4'h1;
    lane_mask = base << lane_index(off, size, big);
  endfunction : lane_mask

  // move low-justified data onto its active lanes
  function automatic logic [DATA_W-1:0] lane_place(
      input logic [DATA_W-1:0] data, input logic [1:0] off,
      input logic [2:0] size, input logic big);
    logic [DATA_W-1:0] keep;
    keep = (size == SIZE_HALF) ? 32'h0000_FFFF :
           (size == SIZE_WORD) ? 32'hFFFF_FFFF : 32'h0000_00FF;
    lane_place = (data & keep) << {lane_index(off, size, big), 3'h0};
  endfunction : lane_place

  // take data off its active lanes, low-justified, upper bits zero
  function automatic logic [DATA_W-1:0] lane_pick(
      input logic [DATA_W-1:0] data, input logic [1:0] off,
      input logic [2:0] size, input logic big);
    logic [DATA_W-1:0] keep;
    keep = (size == SIZE_HALF) ? 32'h0000_FFFF :
           (size == SIZE_WORD) ? 32'hFFFF_FFFF : 32'h0000_00FF;
    lane_pick = (data >> {lane_index(off, size, big), 3'h0}) & keep;
  endfunction : lane_pick

endpackage : bcr_pkg

/* File: hw/bcr_bus_if.sv */
// pipelined bus link joining one master end and one slave end
`timescale 1ns/10ps
interface bcr_bus_if (
  input wire logic hclk,   // the one interface clock
  input wire logic hresetn // bus reset, active low
);
  logic [1:0] htrans; // transfer type
  logic [31:0] haddr; // address
  logic hwrite; // write when high
  logic [2:0] hsize; // transfer size
  logic [2:0] hburst; // burst kind
  logic [31:0] hwdata; // write data
  logic [31:0] hrdata; // read data
  logic hreadyout; // slave ready
  logic hresp; // error response
  logic hready; // ready seen by all
  logic hsel; // slave select

  // single-slave link: no decoder, ready loops straight back
  assign hready = hreadyout;
  assign hsel = 1'h1;

  modport master (
    input hclk, hresetn, hready, hresp, hrdata,
    output htrans, haddr, hwrite, hsize, hburst, hwdata
  );

  modport slave (
    input hclk, hresetn, hsel, hready, htrans, haddr, hwrite, hsize,
    input hburst, hwdata,
    output hreadyout, hresp, hrdata
  );
endinterface : bcr_bus_if

/* File: hw/bcr_slave.sv */
// slave end: flip-flop memory with wait states and error answers
`timescale 1ns/10ps
module bcr_slave #(
  parameter int DEPTH = 16,       // memory words
  parameter bit BIG_ENDIAN = 1'b0 // lane order, fixed per system
) (
  bcr_bus_if.slave bus,             // bus side
  input wire logic stall_i,         // extend the data phase
  output logic wr_pulse_o,          // a write completed
  output logic [31:0] wr_addr_o,    // its address
  output logic [31:0] wr_data_o     // its data, low-justified
);
  localparam int IW = $clog2(DEPTH); // word index width

  // elaboration check: index needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  typedef enum logic [1:0] {SL_IDLE, SL_DATA, SL_ERR1, SL_ERR2}
    bcr_sphase_type;

  typedef struct packed {
    bcr_sphase_type phase;       // data phase progress
    logic ready;                 // drives ready out
    logic resp;                  // drives response
    logic dp_write;              // data phase is a write
    logic [31:0] dp_addr;        // data phase address
    logic [2:0] dp_size;         // data phase size
    logic [31:0] rdata;          // read data register
    logic [DEPTH-1:0][31:0] mem; // storage
    logic wr_pulse;              // write done pulse
    logic [31:0] wr_addr;        // last write address
    logic [31:0] wr_data;        // last write data
  } bcr_slave_type;

  localparam bcr_slave_type RESET_STATE = '{phase: SL_IDLE,
    ready: bcr_pkg::READY_RESET, default: '0};

  bcr_slave_type cur; // registered state
  bcr_slave_type next_cur; // next state
  logic take; // address phase accepted this edge
  logic legal; // size and alignment acceptable
  logic [3:0] mask; // write byte lanes
  logic [31:0] merged; // memory word after write

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  // everything below is sampled on the rising clock edge
  always_comb begin
    next_cur = cur;
    next_cur.wr_pulse = 1'h0;
    mask = bcr_pkg::lane_mask(cur.dp_addr[1:0], cur.dp_size, BIG_ENDIAN);
    merged = cur.mem[cur.dp_addr[IW+1:2]];
    legal = bcr_pkg::is_aligned(bus.haddr[1:0], bus.hsize);
    take = bus.hready && bus.hsel && bus.htrans[1];
    unique case (cur.phase)
      SL_DATA: begin
        if (cur.ready) begin
          // data phase ends; writes land now, byte lanes only
          if (cur.dp_write) begin
            for (int b = 0; b < 4; b++) begin
              if (mask[b]) begin
                merged[b*8 +: 8] = bus.hwdata[b*8 +: 8];
              end
            end
            next_cur.mem[cur.dp_addr[IW+1:2]] = merged;
            next_cur.wr_pulse = 1'h1;
            next_cur.wr_addr = cur.dp_addr;
            next_cur.wr_data = bcr_pkg::lane_pick(bus.hwdata,
              cur.dp_addr[1:0], cur.dp_size, BIG_ENDIAN);
          end
          next_cur.phase = SL_IDLE;
        end else begin
          next_cur.ready = ~stall_i; // wait state while stalled
        end
      end
      SL_ERR1: begin
        // second error cycle: ready rises, response stays error
        next_cur.phase = SL_ERR2;
        next_cur.ready = 1'h1;
        take = 1'h0;
      end
      SL_ERR2: next_cur.phase = SL_IDLE;
      SL_IDLE: next_cur.phase = SL_IDLE;
    endcase
    if (next_cur.phase == SL_IDLE) begin
      next_cur.resp = bcr_pkg::RESP_OKAY;
      next_cur.ready = 1'h1;
    end
    if (take) begin
      next_cur.dp_write = bus.hwrite;
      next_cur.dp_addr = bus.haddr;
      next_cur.dp_size = bus.hsize;
      if (!legal) begin
        // unaligned or too wide: first error cycle holds ready low
        next_cur.phase = SL_ERR1;
        next_cur.ready = 1'h0;
        next_cur.resp = bcr_pkg::RESP_ERROR;
      end else begin
        next_cur.phase = SL_DATA;
        next_cur.ready = ~stall_i;
        next_cur.resp = bcr_pkg::RESP_OKAY;
        // read from the updated copy so a write just ending is seen
        next_cur.rdata = next_cur.mem[bus.haddr[IW+1:2]];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register: one clock, async assert, release on the edge

  always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
    if (!bus.hresetn) begin
      cur <= RESET_STATE; // ready held high
    end else begin // leaves reset on the first edge after release
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops so none moves before the edge

  assign bus.hreadyout = cur.ready;
  assign bus.hresp = cur.resp;
  assign bus.hrdata = cur.rdata;
  assign wr_pulse_o = cur.wr_pulse;
  assign wr_addr_o = cur.wr_addr;
  assign wr_data_o = cur.wr_data;

endmodule : bcr_slave

/* File: hw/bcr_master.sv */
// master end: single and four-beat incrementing transfers
//
// How it works
// - one clock drives all interface logic
// - inputs captured on the rising edge
// - outputs change only after the edge
// - reset active low; other signals active high
// - reset acts at once, no clock needed
// - reset released synchronously after the edge
// - in reset master drives valid levels, idle
// - in reset slave holds ready high
// - aligned means address multiple of size
// - byte 8, half 16, word 32, double 64
// - little-endian: next address, more significant byte
// - big-endian: next address, less significant byte
// - burst: consecutive addresses; incr4 is four beats
// - write data held until ready completes it
`timescale 1ns/10ps
module bcr_master #(
  parameter int DATA_W = 32,      // bus data width
  parameter bit BIG_ENDIAN = 1'b0 // lane order, fixed per system
) (
  bcr_bus_if.master bus,            // bus side
  input wire logic req_valid_i,     // request present
  input wire logic req_write_i,     // write when high
  input wire logic [31:0] req_addr_i, // start address
  input wire logic [2:0] req_size_i,  // transfer size
  input wire logic req_burst4_i,    // four-beat burst when high
  output logic req_ready_o,         // request taken this edge
  input wire logic [31:0] wdata_i,  // write data, low-justified
  output logic wdata_take_o,        // wdata_i taken this edge
  output logic [31:0] rdata_o,      // read data, low-justified
  output logic rvalid_o,            // read beat done pulse
  output logic err_o,               // beat ended with error pulse
  output logic reject_o,            // request refused pulse
  output logic busy_o               // transfers in flight
);

  // elaboration check: lane logic serves a 32-bit bus only
  if (DATA_W != bcr_pkg::DATA_W) begin : g_chk
    $error("DATA_W must be 32");
  end

  typedef enum logic {MS_IDLE, MS_RUN} bcr_mphase_type;

  typedef struct packed {
    bcr_mphase_type phase;  // idle or transfers in flight
    logic [1:0] htrans;     // address phase type
    logic [31:0] haddr;     // address phase address
    logic hwrite;           // address phase direction
    logic [2:0] hsize;      // address phase size
    logic [2:0] hburst;     // address phase burst kind
    logic [1:0] left;       // burst beats still to issue
    logic dp_valid;         // a data phase is open
    logic dp_write;         // data phase direction
    logic [1:0] dp_off;     // data phase byte offset
    logic [2:0] dp_size;    // data phase size
    logic [31:0] hwdata;    // write data on the bus
    logic [31:0] rdata;     // captured read data
    logic rvalid;           // read done pulse
    logic err;              // error pulse
    logic reject;           // refused request pulse
  } bcr_master_type;

  // reset: idle transfer, every control at a defined level
  localparam bcr_master_type RESET_STATE = '{
    phase: MS_IDLE,
    htrans: bcr_pkg::TRANS_IDLE,
    haddr: bcr_pkg::ADDR_RESET,
    hwrite: 1'h0,
    hsize: bcr_pkg::SIZE_BYTE,
    hburst: bcr_pkg::BURST_SINGLE,
    hwdata: bcr_pkg::DATA_RESET,
    rdata: bcr_pkg::DATA_RESET,
    default: '0};

  bcr_master_type cur; // registered state
  bcr_master_type next_cur; // next state
  logic slot_free; // address phase slot frees at this edge
  logic legal; // request size and alignment acceptable
  logic [31:0] step; // address increment per beat

  //////////////////////////////////////////////////////////////////////////
  // handshakes toward the user

  // a new request may enter when no burst beats remain to issue
  assign slot_free = bus.hready && (cur.left == 2'h0);
  assign req_ready_o = slot_free;
  // write data of a beat is taken when its address phase completes
  assign wdata_take_o = bus.hready && cur.htrans[1] && cur.hwrite;
  assign legal = bcr_pkg::is_aligned(req_addr_i[1:0], req_size_i);

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  // inputs feed this logic directly; the state register samples the result on the edge
  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'h0;
    next_cur.err = 1'h0;
    next_cur.reject = 1'h0;
    // incr4 steps by the size in bytes
    step = 32'h0000_0001 << cur.hsize;
    if (bus.hready) begin
      // close the open data phase
      if (cur.dp_valid) begin
        next_cur.err = (bus.hresp == bcr_pkg::RESP_ERROR);
        if (!cur.dp_write) begin
          next_cur.rvalid = 1'h1;
          // pick the active lanes of the read beat
          next_cur.rdata = bcr_pkg::lane_pick(bus.hrdata, cur.dp_off,
            cur.dp_size, BIG_ENDIAN);
        end
      end
      // address phase moves into the data phase
      next_cur.dp_valid = cur.htrans[1];
      next_cur.dp_write = cur.hwrite;
      next_cur.dp_off = cur.haddr[1:0];
      next_cur.dp_size = cur.hsize;
      if (cur.htrans[1] && cur.hwrite) begin
        // lanes follow the system byte order
        next_cur.hwdata = bcr_pkg::lane_place(wdata_i, cur.haddr[1:0],
          cur.hsize, BIG_ENDIAN);
      end
      // choose the next address phase
      if (cur.left != 2'h0) begin
        // next beat of the burst at the following address
        next_cur.htrans = bcr_pkg::TRANS_SEQ;
        next_cur.haddr = cur.haddr + step;
        next_cur.left = cur.left - 2'h1;
      end else if (req_valid_i && legal) begin
        next_cur.htrans = bcr_pkg::TRANS_NONSEQ;
        next_cur.haddr = req_addr_i;
        next_cur.hwrite = req_write_i;
        next_cur.hsize = req_size_i;
        if (req_burst4_i) begin
          next_cur.hburst = bcr_pkg::BURST_INCR4;
          next_cur.left = bcr_pkg::INCR4_LEFT;
        end else begin
          next_cur.hburst = bcr_pkg::BURST_SINGLE;
          next_cur.left = 2'h0;
        end
      end else begin
        // nothing to issue; controls keep their last valid levels
        next_cur.htrans = bcr_pkg::TRANS_IDLE;
        // unaligned or wider than the bus
        next_cur.reject = req_valid_i;
      end
    end
    // while ready is low everything but the rvalid, err and reject pulses holds, write data too
    next_cur.phase = (next_cur.htrans[1] || next_cur.dp_valid) ?
      MS_RUN : MS_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register: one clock, async assert, release on the edge

  // a single edge-triggered process on the bus clock
  always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
    if (!bus.hresetn) begin // active low, acts without a clock
      cur <= RESET_STATE; // idle type, valid controls
    end else begin // first update on the edge after release
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops so none moves ahead of the edge

  assign bus.htrans = cur.htrans;
  assign bus.haddr = cur.haddr;
  assign bus.hwrite = cur.hwrite;
  assign bus.hsize = cur.hsize;
  assign bus.hburst = cur.hburst;
  assign bus.hwdata = cur.hwdata; // stable through wait states
  assign rdata_o = cur.rdata;
  assign rvalid_o = cur.rvalid;
  assign err_o = cur.err;
  assign reject_o = cur.reject;
  assign busy_o = (cur.phase == MS_RUN);

endmodule : bcr_master

/* File: verification/bcr_link_sva.sv */
// link checker: watches the bus between the master and slave ends
`timescale 1ns/10ps
module bcr_link_sva (
  input wire logic hclk, // interface clock
  input wire logic hresetn, // bus reset, active low
  input wire logic [1:0] htrans, // transfer type
  input wire logic [31:0] haddr, // address
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [2:0] hburst, // burst kind
  input wire logic [31:0] hwdata, // write data
  input wire logic hreadyout, // slave ready
  input wire logic hresp // error response
);
  logic accept; // address phase taken this edge
  logic [1:0] beat_cnt; // beats seen of an open four-beat burst
  logic wr_dphase; // a write data phase is open
  assign accept = htrans[1] && hreadyout;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////
  // helper state, reset with the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beat_cnt <= 2'h0;
      wr_dphase <= 1'h0;
    end else begin
      if (hreadyout) wr_dphase <= htrans[1] && hwrite;
      // wraps to zero after the fourth beat
      if (accept && htrans == 2'h2 && hburst == 3'h3) beat_cnt <= 2'h1;
      else if (accept && htrans == 2'h3) beat_cnt <= beat_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset checks must run while reset is held, so no disable here
  a_reset_ready_high: assert property (disable iff (1'b0)
    !hresetn |-> hreadyout && !hresp) else $error("ready low in reset");
  a_reset_trans_idle: assert property (disable iff (1'b0)
    !hresetn |-> htrans == 2'h0) else $error("busy type in reset");
  a_reset_ctrl_valid: assert property (disable iff (1'b0)
    !hresetn |-> haddr == 32'h0 && !hwrite && hsize == 3'h0
    && hburst == 3'h0) else $error("control not at level in reset");
  a_wait_hold_ctrl: assert property (htrans[1] && !hreadyout |=>
    $stable(htrans) && $stable(haddr) && $stable(hsize) && $stable(hwrite))
    else $error("control moved while waiting");
  a_wdata_hold: assert property (wr_dphase && !hreadyout |=>
    $stable(hwdata)) else $error("write data moved while waiting");
  a_burst_addr_step: assert property (accept ##1 htrans == 2'h3 |->
    haddr == $past(haddr) + (32'h1 << hsize)) else $error("beat address");
  a_incr4_beat_count: assert property (accept |->
    ((htrans == 2'h2) == (beat_cnt == 2'h0))) else $error("beat count");
  a_issue_aligned: assert property (htrans[1] |-> hsize <= 3'h2
    && (hsize != 3'h1 || !haddr[0]) && (hsize != 3'h2 || haddr[1:0] == 2'h0))
    else $error("unaligned or oversize transfer issued");
  a_aligned_okay: assert property (accept |=> !hresp)
    else $error("error answer to a legal transfer");

  c_burst_beat: cover property (htrans == 2'h3 && hreadyout);
  c_write_wait: cover property (wr_dphase && !hreadyout);
  c_reset_exit: cover property (disable iff (1'b0) !hresetn ##1 hresetn);
endmodule : bcr_link_sva

/* File: verification/bus_clock_reset_conformance_tb_top.sv */
// bench driving the master user side and watching the slave user side
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module bus_clock_reset_conformance_tb_top;
  logic clk, rst, hresetn; // bench clock and reset
  logic req_valid, req_write, req_burst4, stall; // request inputs and slave stall
  logic [31:0] req_addr; // request address
  logic [2:0] req_size; // request size
  logic [31:0] wdat [0:7]; // write data, one entry per beat
  int widx; // next write data entry
  logic take_seen; // data taken at the coming edge
  logic req_ready, wdata_take, rvalid, err, reject, busy, wr_pulse;
  logic [31:0] rdata, wr_addr, wr_data; // captured outputs
  logic [31:0] rq[$], wa[$], wd[$]; // read data, write address and data
  logic [31:0] x; // popped value
  int rejects, num_errors, check_count;
  assign hresetn = ~rst;

  bcr_bus_if i_bcr_bus_if (.hclk(clk), .hresetn(hresetn));
  bcr_master i_bcr_master (.bus(i_bcr_bus_if), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_size_i(req_size),
    .req_burst4_i(req_burst4), .req_ready_o(req_ready),
    .wdata_i(wdat[widx[2:0]]), .wdata_take_o(wdata_take), .rdata_o(rdata),
    .rvalid_o(rvalid), .err_o(err), .reject_o(reject), .busy_o(busy));
  bcr_slave i_bcr_slave (.bus(i_bcr_bus_if), .stall_i(stall),
    .wr_pulse_o(wr_pulse), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  bcr_link_sva i_bcr_link_sva (.hclk(clk), .hresetn(hresetn),
    .htrans(i_bcr_bus_if.htrans), .haddr(i_bcr_bus_if.haddr),
    .hwrite(i_bcr_bus_if.hwrite), .hsize(i_bcr_bus_if.hsize),
    .hburst(i_bcr_bus_if.hburst), .hwdata(i_bcr_bus_if.hwdata),
    .hreadyout(i_bcr_bus_if.hreadyout), .hresp(i_bcr_bus_if.hresp));

  ////////////////////////////////////////////////////////////////////////
  // clock, monitors and run control
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // mid-cycle sampling: registered outputs are settled there
  always @(negedge clk) begin
    if (rvalid) rq.push_back(rdata);
    if (wr_pulse) begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end
    if (reject) rejects++;
    take_seen = wdata_take;
  end
  always @(posedge clk) if (take_seen) #1 widx++;

  task automatic complete_run();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // hold request until ready is seen at an edge
  task automatic issue(input logic w, input logic [31:0] a,
                       input logic [2:0] s, input logic b4);
    logic r;
    req_write = w;
    req_addr = a;
    req_size = s;
    req_burst4 = b4;
    req_valid = 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk) r = req_ready;
      @(posedge clk);
      if (r === 1'h1) break;
    end
    // drop valid, then let an edge pass so the next call never
    // raises it again in the same time step
    #1 req_valid = 1'h0;
    @(posedge clk);
    #1;
  endtask : issue

  // bounded wait for the link to drain
  task automatic settle();
    repeat (4) @(posedge clk);
    for (int n = 0; n < 60 && busy !== 1'h0; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_state();
    `CHK(i_bcr_bus_if.hreadyout, 1'h1)
    `CHK(i_bcr_bus_if.htrans, 2'h0)
    `CHK(i_bcr_bus_if.haddr, 32'h0)
    `CHK(req_ready, 1'h1)
    $display("reset state test done");
  endtask : t_reset_state

  task automatic t_endian();
    widx = 0;
    wdat[0] = 32'h4433_2211;
    issue(1'h1, 32'h10, bcr_pkg::SIZE_WORD, 1'h0);
    for (int i = 0; i < 4; i++) issue(1'h0, 32'h10 + i, bcr_pkg::SIZE_BYTE, 1'h0);
    issue(1'h0, 32'h12, bcr_pkg::SIZE_HALF, 1'h0);
    settle();
    x = wd.pop_front();
    `CHK(x, 32'h4433_2211)
    for (int i = 0; i < 4; i++) begin
      x = rq.pop_front();
      `CHK(x, {24'h0, 8'h11 * (i + 1)})
    end
    x = rq.pop_front();
    `CHK(x, 32'h0000_4433)
    widx = 0;
    wdat[0] = 32'h55;
    issue(1'h1, 32'h12, bcr_pkg::SIZE_BYTE, 1'h0);
    issue(1'h0, 32'h10, bcr_pkg::SIZE_WORD, 1'h0);
    settle();
    x = wa.pop_front();
    `CHK(x, 32'h10)
    x = wa.pop_front();
    `CHK(x, 32'h12)
    x = rq.pop_front();
    `CHK(x, 32'h4455_2211)
    $display("endian test done");
  endtask : t_endian

  task automatic t_refuse();
    int r0;
    r0 = rejects;
    wa.delete();
    issue(1'h1, 32'h11, bcr_pkg::SIZE_WORD, 1'h0);
    issue(1'h0, 32'h13, bcr_pkg::SIZE_HALF, 1'h0);
    issue(1'h0, 32'h10, bcr_pkg::SIZE_DWORD, 1'h0);
    issue(1'h1, 32'h12, bcr_pkg::SIZE_WORD, 1'h0);
    settle();
    `CHK(rejects - r0, 4)
    `CHK(wa.size(), 0)
    $display("refusal test done");
  endtask : t_refuse

  task automatic t_burst();
    wa.delete();
    wd.delete();
    for (int i = 0; i < 4; i++) wdat[i] = 32'hA3A2_A1A0 + 32'h1010_1010 * i;
    widx = 0;
    stall = 1'h1;
    issue(1'h1, 32'h20, bcr_pkg::SIZE_WORD, 1'h1);
    repeat (3) @(posedge clk);
    #1 stall = 1'h0;
    settle();
    issue(1'h0, 32'h20, bcr_pkg::SIZE_HALF, 1'h1);
    settle();
    for (int i = 0; i < 4; i++) begin
      x = wa.pop_front();
      `CHK(x, 32'h20 + 4 * i)
      x = wd.pop_front();
      `CHK(x, wdat[i])
      x = rq.pop_front();
      `CHK(x, (wdat[i / 2] >> (16 * (i % 2))) & 32'hFFFF)
    end
    $display("burst test done");
  endtask : t_burst

  task automatic t_async();
    stall = 1'h1;
    issue(1'h0, 32'h20, bcr_pkg::SIZE_WORD, 1'h0);
    @(negedge clk);
    #1 rst = 1'h1;
    #1;
    `CHK(i_bcr_bus_if.hreadyout, 1'h1)
    `CHK(i_bcr_bus_if.htrans, 2'h0)
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    stall = 1'h0;
    rq.delete();
    widx = 0;
    wdat[0] = 32'hCAFE_0001;
    issue(1'h1, 32'h30, bcr_pkg::SIZE_WORD, 1'h0);
    issue(1'h0, 32'h30, bcr_pkg::SIZE_WORD, 1'h0);
    settle();
    x = rq.pop_front();
    `CHK(x, 32'hCAFE_0001)
    $display("async reset test done");
  endtask : t_async

  initial begin
    rst = 1'h1;
    {req_valid, req_write, req_burst4, stall} = 4'h0;
    req_addr = 32'h0;
    req_size = 3'h0;
    widx = 0;
    take_seen = 1'h0;
    {rejects, num_errors, check_count} = {32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++) wdat[i] = 32'h0;
    repeat (10) @(posedge clk);
    #1 t_reset_state();
    repeat (10) @(posedge clk);
    #1 rst = 1'h0; // released just after an edge
    t_endian();
    t_refuse();
    t_burst();
    t_async();
    complete_run();
  end

  // watchdog: all tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : bus_clock_reset_conformance_tb_top
